// file: core/avm_pkg.sv
// register map, field layout, encodings and reset values of the entry matcher
package avm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VID  = 8'h04;
  localparam logic [7:0] OFS_SADR = 8'h08;
  localparam logic [7:0] OFS_SMSK = 8'h0C;
  localparam logic [7:0] OFS_CNT  = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // control field positions
  localparam int CTRL_TAG  = 0;
  localparam int CTRL_VEN  = 2;
  localparam int CTRL_PEN  = 3;
  localparam int CTRL_OPS  = 4;
  localparam int CTRL_RR   = 6;
  localparam int CTRL_SND  = 8;
  localparam int CTRL_ARP  = 10;
  localparam int CTRL_DENY = 11;
  // vlan register field positions and widths
  localparam int VID_LSB = 0;
  localparam int VID_W   = 12;
  localparam int PRI_LSB = 16;
  localparam int PRI_W   = 3;
  // status bit positions
  localparam int STAT_HIT  = 0;
  localparam int STAT_DENY = 1;
  // tag presence settings
  typedef enum logic [1:0] {TAG_ANY = 2'h0, TAG_ON = 2'h1, TAG_OFF = 2'h2} avm_tag_t;
  // opcode type settings
  typedef enum logic [1:0] {
    OPS_ANY = 2'h0, OPS_ARP = 2'h1, OPS_RARP = 2'h2, OPS_OTHER = 2'h3
  } avm_ops_t;
  // request/reply settings
  typedef enum logic [1:0] {RR_ANY = 2'h0, RR_REQ = 2'h1, RR_REP = 2'h2} avm_rr_t;
  // sender address filter modes
  typedef enum logic [1:0] {SND_ANY = 2'h0, SND_HOST = 2'h1, SND_NET = 2'h2} avm_snd_t;
  // arp opcode field values
  localparam logic [15:0] OPC_ARP_REQ  = 16'h0001;
  localparam logic [15:0] OPC_ARP_REP  = 16'h0002;
  localparam logic [15:0] OPC_RARP_REQ = 16'h0003;
  localparam logic [15:0] OPC_RARP_REP = 16'h0004;
  // reset values
  localparam logic [11:0] VID_RST = 12'h001;
  localparam logic [2:0]  PRI_RST = 3'h0;
endpackage

// file: core/avm_matcher.sv
// one access control entry: vlan, tag priority and arp criteria with apb registers
//
// Contract
// R1: the tag filter is any, tagged only or untagged only, and resets to any.
// R2: with the vlan filter off the frame's vlan identifier is ignored.
// R3: with the vlan filter on only frames carrying the set identifier 1..4095 match; the vid register also accepts and matches 0.
// R4: the priority criterion is off or a value 0..7 that the frame's priority must equal.
// R5: the opcode type criterion is any, arp, rarp or neither of them.
// R6: the request/reply criterion is any, request only or reply only.
// R7: opcode, request/reply and sender address criteria count only for arp entries.
// R8: with the sender filter off the sender address is not examined.
// R9: in host mode the sender address must equal the set address exactly.
// R10: in network mode only the bits selected by the mask must be equal.
// R11: a matching frame is discarded when the entry denies and passed when it permits.
// R12: the hit counter goes up by one for every matching frame.
// R13: a frame matches only when every active criterion holds at once.
`timescale 1ns/10ps
module avm_matcher
  import avm_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // parsed frame from the receive path
  input  wire logic        frame_valid,
  input  wire logic        frame_tagged,
  input  wire logic [11:0] frame_vid,
  input  wire logic [2:0]  frame_pri,
  input  wire logic        frame_is_arp,
  input  wire logic [15:0] frame_arp_opcode_field,
  input  wire logic [31:0] frame_sender_protocol_address,
  // verdict, one cycle after the frame
  output logic             match_valid,
  output logic             match_hit,
  output logic             frame_permit,
  output logic             frame_discard
);
  import avm_pkg::*;

  typedef struct packed {
    logic [1:0]       tag_sel;
    logic             vid_en;
    logic             pri_en;
    logic [1:0]       ops_sel;
    logic [1:0]       rr_sel;
    logic [1:0]       snd_sel;
    logic             arp_entry;
    logic             deny;
    logic [11:0]      vid;
    logic [2:0]       pri;
    logic [31:0]      sadr;
    logic [31:0]      smsk;
    logic [CNT_W-1:0] cnt;
    logic [31:0]      rdata;
    logic             mval;
    logic             mhit;
    logic             permit;
    logic             discard;
  } avm_state_t;

  avm_state_t st_reg;
  avm_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true for every offset the slave decodes
  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_VID || a == OFS_SADR ||
           a == OFS_SMSK || a == OFS_CNT || a == OFS_STAT;
  endfunction

  // kind of opcode: arp, rarp or other
  function automatic logic [1:0] opc_kind(input logic [15:0] code);
    if (code == OPC_ARP_REQ || code == OPC_ARP_REP) return OPS_ARP;
    if (code == OPC_RARP_REQ || code == OPC_RARP_REP) return OPS_RARP;
    return OPS_OTHER;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // criteria

  logic ok_tag;
  logic ok_vid;
  logic ok_pri;
  logic ok_type;
  logic ok_ops;
  logic ok_rr;
  logic ok_snd;
  logic hit;
  logic is_req;
  logic is_rep;
  logic wr_fire;
  logic rd_setup;

  // request/reply decode of the opcode field
  assign is_req = frame_arp_opcode_field == OPC_ARP_REQ ||
                  frame_arp_opcode_field == OPC_RARP_REQ;
  assign is_rep = frame_arp_opcode_field == OPC_ARP_REP ||
                  frame_arp_opcode_field == OPC_RARP_REP;

  // tag presence
  assign ok_tag = (st_reg.tag_sel == TAG_ON)  ? frame_tagged :
                  (st_reg.tag_sel == TAG_OFF) ? !frame_tagged : 1'b1; // R1
  // vlan identifier
  assign ok_vid = !st_reg.vid_en || frame_vid == st_reg.vid; // R2 R3
  // tag priority
  assign ok_pri = !st_reg.pri_en || frame_pri == st_reg.pri; // R4
  // arp entries take only arp frames
  assign ok_type = !st_reg.arp_entry || frame_is_arp; // R7

  // opcode type, bypassed for non-arp entries
  assign ok_ops = !st_reg.arp_entry || st_reg.ops_sel == OPS_ANY ||
                  opc_kind(frame_arp_opcode_field) == st_reg.ops_sel; // R5 R7

  // request or reply
  assign ok_rr = !st_reg.arp_entry ||
                 (st_reg.rr_sel == RR_REQ ? is_req :
                  st_reg.rr_sel == RR_REP ? is_rep : 1'b1); // R6 R7

  // sender protocol address
  always_comb begin
    ok_snd = 1'b1; // R8
    if (st_reg.arp_entry) begin // R7
      if (st_reg.snd_sel == SND_HOST) begin
        ok_snd = frame_sender_protocol_address == st_reg.sadr; // R9
      end else if (st_reg.snd_sel == SND_NET) begin
        ok_snd = ((frame_sender_protocol_address ^ st_reg.sadr) & st_reg.smsk) == 32'h0; // R10
      end
    end
  end

  // all active criteria at once
  assign hit = ok_tag && ok_vid && ok_pri && ok_type && ok_ops && ok_rr && ok_snd; // R13

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign wr_fire  = psel && penable && pwrite && mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;

  // zero wait state, unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = st_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    // verdict for the frame seen this cycle
    st_next.mval    = frame_valid;
    st_next.mhit    = frame_valid && hit;
    st_next.permit  = frame_valid && hit && !st_reg.deny; // R11
    st_next.discard = frame_valid && hit && st_reg.deny; // R11
    // register writes
    if (wr_fire) begin
      case (paddr)
        OFS_CTRL: begin
          st_next.tag_sel   = pwdata[CTRL_TAG +: 2];
          st_next.vid_en    = pwdata[CTRL_VEN];
          st_next.pri_en    = pwdata[CTRL_PEN];
          st_next.ops_sel   = pwdata[CTRL_OPS +: 2];
          st_next.rr_sel    = pwdata[CTRL_RR +: 2];
          st_next.snd_sel   = pwdata[CTRL_SND +: 2];
          st_next.arp_entry = pwdata[CTRL_ARP];
          st_next.deny      = pwdata[CTRL_DENY];
        end
        OFS_VID: begin
          st_next.vid = pwdata[VID_LSB +: VID_W];
          st_next.pri = pwdata[PRI_LSB +: PRI_W];
        end
        OFS_SADR: st_next.sadr = pwdata;
        OFS_SMSK: st_next.smsk = pwdata;
        OFS_CNT:  st_next.cnt = '0;
        default:  st_next.cnt = st_reg.cnt;
      endcase
    end
    // a hit in the clearing cycle still counts
    if (frame_valid && hit) begin
      st_next.cnt = (wr_fire && paddr == OFS_CNT) ? CNT_W'(1) : st_reg.cnt + CNT_W'(1); // R12
    end
    // read data captured in the setup cycle
    if (rd_setup) begin
      st_next.rdata = 32'h0;
      case (paddr)
        OFS_CTRL: begin
          st_next.rdata[CTRL_TAG +: 2] = st_reg.tag_sel;
          st_next.rdata[CTRL_VEN]      = st_reg.vid_en;
          st_next.rdata[CTRL_PEN]      = st_reg.pri_en;
          st_next.rdata[CTRL_OPS +: 2] = st_reg.ops_sel;
          st_next.rdata[CTRL_RR +: 2]  = st_reg.rr_sel;
          st_next.rdata[CTRL_SND +: 2] = st_reg.snd_sel;
          st_next.rdata[CTRL_ARP]      = st_reg.arp_entry;
          st_next.rdata[CTRL_DENY]     = st_reg.deny;
        end
        OFS_VID: begin
          st_next.rdata[VID_LSB +: VID_W] = st_reg.vid;
          st_next.rdata[PRI_LSB +: PRI_W] = st_reg.pri;
        end
        OFS_SADR: st_next.rdata = st_reg.sadr;
        OFS_SMSK: st_next.rdata = st_reg.smsk;
        OFS_CNT:  st_next.rdata[CNT_W-1:0] = st_reg.cnt;
        OFS_STAT: begin
          st_next.rdata[STAT_HIT]  = st_reg.mhit;
          st_next.rdata[STAT_DENY] = st_reg.discard;
        end
        default:  st_next.rdata = 32'h0;
      endcase
    end
  end

  // state register, tag filter resets to any
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0; // R1
      st_reg.tag_sel <= TAG_ANY; // R1
      st_reg.vid     <= VID_RST;
      st_reg.pri     <= PRI_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // verdict outputs
  assign match_valid   = st_reg.mval;
  assign match_hit     = st_reg.mhit;
  assign frame_permit  = st_reg.permit;
  assign frame_discard = st_reg.discard;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tag_only;
    frame_valid && st_reg.tag_sel == TAG_ON && !frame_tagged |=> match_valid && !match_hit;
  endproperty
  a_tag_only: assert property (p_tag_only) else $error("untagged frame hit tagged-only entry"); // R1

  property p_vid_any;
    frame_valid && !st_reg.vid_en && ok_tag && ok_pri && ok_type && ok_ops && ok_rr && ok_snd
      |=> match_hit;
  endproperty
  a_vid_any: assert property (p_vid_any) else $error("vlan id affected a don't-care entry"); // R2

  property p_vid_set;
    frame_valid && st_reg.vid_en && frame_vid != st_reg.vid |=> !match_hit;
  endproperty
  a_vid_set: assert property (p_vid_set) else $error("vlan id mismatch still hit"); // R3

  property p_pri_set;
    frame_valid && st_reg.pri_en && frame_pri != st_reg.pri |=> !match_hit;
  endproperty
  a_pri_set: assert property (p_pri_set) else $error("priority mismatch still hit"); // R4

  property p_ops_rarp;
    frame_valid && st_reg.arp_entry && st_reg.ops_sel == OPS_RARP &&
      frame_arp_opcode_field == OPC_ARP_REQ |=> !match_hit;
  endproperty
  a_ops_rarp: assert property (p_ops_rarp) else $error("arp opcode hit rarp entry"); // R5

  property p_rr_req;
    frame_valid && st_reg.arp_entry && st_reg.rr_sel == RR_REQ && is_rep |=> !match_hit;
  endproperty
  a_rr_req: assert property (p_rr_req) else $error("reply hit request-only entry"); // R6

  property p_non_arp;
    frame_valid && !st_reg.arp_entry && ok_tag && ok_vid && ok_pri |=> match_hit;
  endproperty
  a_non_arp: assert property (p_non_arp) else $error("arp criteria used on non-arp entry"); // R7

  property p_snd_host;
    frame_valid && st_reg.arp_entry && st_reg.snd_sel == SND_HOST &&
      frame_sender_protocol_address != st_reg.sadr |=> !match_hit;
  endproperty
  a_snd_host: assert property (p_snd_host) else $error("host sender mismatch hit"); // R9

  property p_snd_net;
    frame_valid && st_reg.arp_entry && st_reg.snd_sel == SND_NET &&
      ((frame_sender_protocol_address ^ st_reg.sadr) & st_reg.smsk) != 32'h0 |=> !match_hit;
  endproperty
  a_snd_net: assert property (p_snd_net) else $error("network sender mismatch hit"); // R10

  property p_action;
    match_valid && match_hit |-> frame_discard == $past(st_reg.deny) && frame_permit != frame_discard;
  endproperty
  a_action: assert property (p_action) else $error("action disagrees with entry"); // R11

  property p_count;
    frame_valid && hit && !(wr_fire && paddr == OFS_CNT) |=> st_reg.cnt == $past(st_reg.cnt) + CNT_W'(1);
  endproperty
  a_count: assert property (p_count) else $error("hit counter did not advance"); // R12

  property p_and;
    frame_valid |=> match_hit == $past(ok_tag && ok_vid && ok_pri && ok_type && ok_ops && ok_rr && ok_snd);
  endproperty
  a_and: assert property (p_and) else $error("verdict is not the and of criteria"); // R13

endmodule

// file: tb/avm_rx_model.sv
// receive path model: offers parsed frames to the entry matcher
`timescale 1ns/10ps
module avm_rx_model (
  // clock
  input  wire logic        pclk,
  // parsed frame
  output logic             frame_valid,
  output logic             frame_tagged,
  output logic [11:0]      frame_vid,
  output logic [2:0]       frame_pri,
  output logic             frame_is_arp,
  output logic [15:0]      frame_arp_opcode_field,
  output logic [31:0]      frame_sender_protocol_address
);
  // idle at time zero: no frame offered
  initial begin
    frame_valid = 1'b0;
    {frame_tagged, frame_vid, frame_pri, frame_is_arp} = '0;
    {frame_arp_opcode_field, frame_sender_protocol_address} = '0;
  end
  // one frame for one cycle, then attributes turn to the inverse so nothing stale matches
  task automatic send(input logic tg, input logic [11:0] v, input logic [2:0] p,
                      input logic a, input logic [15:0] o, input logic [31:0] s);
    @(posedge pclk);
    frame_valid <= 1'b1;
    {frame_tagged, frame_vid, frame_pri, frame_is_arp, frame_arp_opcode_field,
     frame_sender_protocol_address} <= {tg, v, p, a, o, s};
    @(posedge pclk);
    frame_valid <= 1'b0;
    {frame_tagged, frame_vid, frame_pri, frame_is_arp, frame_arp_opcode_field,
     frame_sender_protocol_address} <= ~{tg, v, p, a, o, s};
  endtask
endmodule

// file: tb/avm_matcher_tb_top.sv
// self-checking bench of the entry matcher: apb tasks and frame tests
`timescale 1ns/10ps
module avm_matcher_tb_top;
  import avm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, match_valid, match_hit, frame_permit, frame_discard;
  logic frame_valid, frame_tagged, frame_is_arp;
  logic [11:0] frame_vid;
  logic [2:0]  frame_pri;
  logic [15:0] frame_arp_opcode_field;
  logic [31:0] frame_sender_protocol_address;
  int errors, cmp_count, hits;
  logic deny;
  avm_matcher i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_valid(frame_valid), .frame_tagged(frame_tagged),
    .frame_vid(frame_vid), .frame_pri(frame_pri), .frame_is_arp(frame_is_arp),
    .frame_arp_opcode_field(frame_arp_opcode_field),
    .frame_sender_protocol_address(frame_sender_protocol_address),
    .match_valid(match_valid), .match_hit(match_hit), .frame_permit(frame_permit),
    .frame_discard(frame_discard));
  avm_rx_model i_rx (.pclk(pclk), .frame_valid(frame_valid), .frame_tagged(frame_tagged),
    .frame_vid(frame_vid), .frame_pri(frame_pri), .frame_is_arp(frame_is_arp),
    .frame_arp_opcode_field(frame_arp_opcode_field),
    .frame_sender_protocol_address(frame_sender_protocol_address));
  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, ee);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, ee);
  endtask
  // control word from field values; deny remembered for verdict checks
  task automatic cfg(input int tg, ven, pen, ops, rr, snd, arp, dn);
    deny = dn[0];
    wr(OFS_CTRL, 32'(tg) << CTRL_TAG | 32'(ven) << CTRL_VEN | 32'(pen) << CTRL_PEN |
       32'(ops) << CTRL_OPS | 32'(rr) << CTRL_RR | 32'(snd) << CTRL_SND |
       32'(arp) << CTRL_ARP | 32'(dn) << CTRL_DENY, 1'b0);
  endtask
  // one frame and its verdict one cycle later
  task automatic fr(input logic tg, input logic [11:0] v, input logic [2:0] p,
                    input logic a, input logic [15:0] o, input logic [31:0] s, input logic h);
    i_rx.send(tg, v, p, a, o, s);
    #1;
    chk(match_valid, 1'b1);
    chk(match_hit, h);
    chk(frame_permit, h & ~deny);
    chk(frame_discard, h & deny);
    hits += int'(h);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  // test sequence
  initial begin
    logic ia, ir, rq, rp, eo, er;
    errors = 0;
    cmp_count = 0;
    hits = 0;
    deny = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(OFS_VID, 32'(VID_RST), 1'b0);
    rd(OFS_CNT, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(8'h24, 32'hFFFF_FFFF, 1'b1);
    fr(1'b0, 12'h123, 3'h5, 1'b0, 16'h0, 32'h0, 1'b1);
    for (int t = 1; t <= 2; t++) begin
      cfg(t, 0, 0, 0, 0, 0, 0, 0);
      fr(1'b1, 12'h001, 3'h0, 1'b0, 16'h0, 32'h0, t == 1);
      fr(1'b0, 12'h001, 3'h0, 1'b0, 16'h0, 32'h0, t == 2);
    end
    wr(OFS_VID, 32'h0007_0FFF, 1'b0);
    cfg(0, 1, 0, 0, 0, 0, 0, 0);
    fr(1'b1, 12'hFFF, 3'h2, 1'b0, 16'h0, 32'h0, 1'b1);
    fr(1'b1, 12'hFFE, 3'h2, 1'b0, 16'h0, 32'h0, 1'b0);
    cfg(0, 0, 1, 0, 0, 0, 0, 0);
    fr(1'b1, 12'h00A, 3'h7, 1'b0, 16'h0, 32'h0, 1'b1);
    fr(1'b1, 12'hFFF, 3'h6, 1'b0, 16'h0, 32'h0, 1'b0);
    cfg(0, 1, 1, 0, 0, 0, 0, 0);
    fr(1'b1, 12'hFFF, 3'h7, 1'b0, 16'h0, 32'h0, 1'b1);
    fr(1'b1, 12'hFFF, 3'h0, 1'b0, 16'h0, 32'h0, 1'b0);
    // every opcode type and request/reply setting against opcodes 1..5
    for (int ot = 0; ot < 4; ot++) begin
      for (int r = 0; r < 3; r++) begin
        cfg(0, 0, 0, ot, r, 0, 1, 0);
        for (int c = 1; c <= 5; c++) begin
          ia = c <= 2;
          ir = c == 3 || c == 4;
          rq = c == 1 || c == 3;
          rp = c == 2 || c == 4;
          eo = ot == 0 || (ot == 1 && ia) || (ot == 2 && ir) || (ot == 3 && !(ia || ir));
          er = r == 0 || (r == 1 && rq) || (r == 2 && rp);
          fr(1'b0, 12'h1, 3'h0, 1'b1, 16'(c), 32'h0, eo & er);
        end
      end
    end
    // sender address: host, network, don't-care
    wr(OFS_SADR, 32'hC0A8_0105, 1'b0);
    wr(OFS_SMSK, 32'hFFFF_FF00, 1'b0);
    cfg(0, 0, 0, 0, 0, 1, 1, 0);
    fr(1'b0, 12'h1, 3'h0, 1'b1, OPC_ARP_REQ, 32'hC0A8_0105, 1'b1);
    fr(1'b0, 12'h1, 3'h0, 1'b1, OPC_ARP_REQ, 32'hC0A8_0106, 1'b0);
    cfg(0, 0, 0, 0, 0, 2, 1, 1);
    fr(1'b0, 12'h1, 3'h0, 1'b1, OPC_ARP_REP, 32'hC0A8_01FE, 1'b1);
    fr(1'b0, 12'h1, 3'h0, 1'b1, OPC_ARP_REP, 32'hC0A8_0205, 1'b0);
    cfg(0, 0, 0, 0, 0, 0, 1, 0);
    fr(1'b0, 12'h1, 3'h0, 1'b1, OPC_RARP_REP, 32'h0, 1'b1);
    fr(1'b0, 12'h1, 3'h0, 1'b0, OPC_RARP_REP, 32'h0, 1'b0);
    // arp criteria set but entry is not arp: they must not count
    cfg(0, 0, 0, 1, 2, 1, 0, 1);
    fr(1'b0, 12'h1, 3'h0, 1'b0, OPC_RARP_REQ, 32'h0, 1'b1);
    // status holds the verdict of the frame taken at the edge before the read setup
    fork
      i_rx.send(1'b0, 12'h1, 3'h0, 1'b0, OPC_RARP_REQ, 32'h0);
      begin
        @(posedge pclk);
        rd(OFS_STAT, 32'h3, 1'b0);
      end
    join
    hits++;
    rd(OFS_CNT, 32'(hits), 1'b0);
    wr(OFS_CNT, 32'h0, 1'b0);
    rd(OFS_CNT, 32'h0, 1'b0);
    report_and_stop();
  end
endmodule
